/* rtl/mode_reg_readout.sv */
// Mode-register read path: command decode, readout burst, strobes
//
// What the document asks of this block and its controller
// [R1] CS low, CA3..0 = 1000 decodes read
// [R2] Address from CA1f..0f and CA9r..4r
// [R3] Falling bits form the address top
// [R4] Register data on DQ7..0 first beat
// [R5] Later beats of ordinary reads undefined
// [R6] DQ8 and above undefined whole burst of ordinary reads
// [R7] All strobe pairs toggle during burst
// [R8] Readout burst is four beats fixed
// [R9] Controller never interrupts a readout; bench dup reads send a second read into the busy window
// [R10] Command period two cycles, only no-ops
// [R11] Reserved or write-only reads give undefined
// [R12] Controller spaces read to write
// [R13] Controller spaces read to mode write
// [R14] Controller spaces read burst to readout
// [R15] Controller spaces write burst to readout
// [R16] Terminated bursts use effective length
// [R17] Temperature status refreshed within 32 ms
// [R18] Status fresh after self refresh exit
// [R19] Controller polls temperature often enough
// [R20] Pattern A is 1,0,1,0
// [R21] Pattern B is 0,0,1,1
// [R22] Pattern on DQ0, 8, 16, 24
// [R23] Other lines copy line 0
// [R24] Controller reads patterns only when idle
// [R25] Readout allowed with banks active
`timescale 1ns/1ps
`default_nettype none

module mode_reg_readout
  import mrr_pkg::*;
#(
  parameter int     DQ_WIDTH     = 32,
  parameter int     READ_LATENCY = 3,
  parameter longint SENSOR_CYC   = SENSOR_INTERVAL_CYC
)
(
  input  wire logic                  sys_clk,
  input  wire logic                  srst,
  input  wire logic                  chip_select_n,
  input  wire logic [9:0]            command_address,
  input  wire logic [9:0]            command_address_fall,
  input  wire logic                  banks_active,
  input  wire logic [7:0]            sensor_code,
  input  wire logic                  wake_event,
  input  wire logic                  cfg_wr_en,
  input  wire logic [7:0]            cfg_wr_addr,
  input  wire logic [7:0]            cfg_wr_data,
  output var  logic [DQ_WIDTH-1:0]   dq_out,
  output var  logic                  dq_oe,
  output var  logic [DQ_WIDTH/8-1:0] dqs_t,
  output var  logic [DQ_WIDTH/8-1:0] dqs_c,
  output var  logic                  dqs_oe,
  output var  logic                  bank_active_state
);

  localparam int LANES = DQ_WIDTH / 8;

  // ==========================================================
  // Command decode
  // ==========================================================
  // Rising-edge half of a mode-register read
  wire is_read_cmd = !chip_select_n
                   && (command_address[3:0] == 4'b1000); // see [R1]

  rd_state_t   state;        // Decoder state
  rd_state_t   next_state;   // Next decoder state
  logic [5:0]  rise_bits;    // Rising-edge address bits kept for the falling half
  logic [7:0]  sel_addr;     // Selected register address
  logic [7:0]  lat_cnt;      // Latency counter to first beat
  logic [1:0]  beat;         // Current data beat
  logic        pat_a;        // Reading pattern A
  logic        pat_b;        // Reading pattern B
  logic        reg_is_temp;  // Reading temperature status

  // Full address: falling bits above rising bits
  wire [7:0] full_addr = {command_address_fall[1:0], rise_bits}; // see [R2] see [R3]

  // ==========================================================
  // Register sources
  // ==========================================================
  logic [7:0] temp_status;   // Temperature status value
  logic [7:0] store_data;    // Other register contents

  temp_sampler #(
    .INTERVAL_CYC (SENSOR_CYC)
  ) u_temp (
    .sys_clk     (sys_clk),
    .srst        (srst),
    .sensor_code (sensor_code),
    .wake_event  (wake_event),
    .status      (temp_status)
  );

  mode_reg_store #(
    .DEPTH (256)
  ) u_store (
    .sys_clk (sys_clk),
    .srst    (srst),
    .wr_en   (cfg_wr_en),
    .wr_addr (cfg_wr_addr),
    .wr_data (cfg_wr_data),
    .rd_addr (sel_addr),
    .rd_data (store_data)
  );

  // ==========================================================
  // State transitions
  // ==========================================================
  wire lat_done   = (lat_cnt == 8'(READ_LATENCY - 1));
  wire burst_last = (beat == 2'(BURST_BEATS - 1)); // see [R8]

  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (is_read_cmd)
          next_state = ST_FALL;
      ST_FALL:
        // Second command cycle; only no-ops accepted until burst ends
        next_state = ST_WAIT; // see [R10]
      ST_WAIT:
        if (lat_done)
          next_state = ST_BURST;
      ST_BURST:
        if (burst_last)
          next_state = ST_IDLE; // see [R9]
      default:
        next_state = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // Address capture
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      rise_bits <= 6'h00;
      sel_addr  <= 8'h00;
    end
    else if (state == ST_IDLE && is_read_cmd)
      rise_bits <= command_address[9:4]; // see [R2]
    else if (state == ST_FALL)
      sel_addr <= full_addr;
  end

  // Latency and beat counters
  always_ff @(posedge sys_clk)
  begin
    if (srst || state != ST_WAIT)
      lat_cnt <= 8'h00;
    else
      lat_cnt <= lat_cnt + 8'h01;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst || state != ST_BURST)
      beat <= 2'b00;
    else
      beat <= beat + 2'b01;
  end

  // ==========================================================
  // Data selection
  // ==========================================================
  assign pat_a       = (sel_addr == ADDR_TRAIN_A);
  assign pat_b       = (sel_addr == ADDR_TRAIN_B);
  assign reg_is_temp = (sel_addr == ADDR_TEMP_STATUS);

  // Serial pattern bit for this beat
  wire pat_bit = pat_a ? PATTERN_A[beat]   // see [R20]
                       : PATTERN_B[beat];  // see [R21]
  wire is_pat  = pat_a || pat_b;

  // Register byte: only valid on first beat
  wire [7:0] reg_byte = reg_is_temp ? temp_status : store_data;
  wire [7:0] low_byte = (beat == 2'b00) ? reg_byte      // see [R4]
                                        : UNDEF_FILL;   // see [R5]

  // Whole bus value for the next beat
  logic [DQ_WIDTH-1:0] next_dq;
  always_comb
  begin
    next_dq = '0; // see [R6]
    if (is_pat)
    begin
      for (int i = 0; i < LANES; i++)
        next_dq[i*8 +: 8] = {8{pat_bit}}; // see [R22] see [R23]
    end
    else
      next_dq[7:0] = low_byte;
  end

  // ==========================================================
  // Output drivers
  // ==========================================================
  wire in_burst = (state == ST_BURST);

  // Data and enable
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      dq_out <= '0;
      dq_oe  <= 1'b0;
    end
    else
    begin
      dq_out <= in_burst ? next_dq : '0;
      dq_oe  <= in_burst;
    end
  end

  // Strobes toggle once per beat for the whole burst
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      dqs_t  <= '0;
      dqs_c  <= '1;
      dqs_oe <= 1'b0;
    end
    else if (in_burst)
    begin
      dqs_t  <= {LANES{~beat[0]}}; // see [R7]
      dqs_c  <= {LANES{beat[0]}};
      dqs_oe <= 1'b1;
    end
    else
    begin
      dqs_t  <= '0;
      dqs_c  <= '1;
      dqs_oe <= 1'b0;
    end
  end

  // Bank state is untouched by a readout
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      bank_active_state <= 1'b0;
    else
      bank_active_state <= banks_active; // see [R25]
  end

endmodule // mode_reg_readout

`default_nettype wire

/* rtl/mode_reg_store.sv */
// Small mode-register storage with registered read data
`timescale 1ns/1ps
`default_nettype none

module mode_reg_store
  import mrr_pkg::*;
#(
  parameter int DEPTH = 256
)
(
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic [7:0] rd_addr,
  output var  logic [7:0] rd_data
);

  logic [7:0] mem [DEPTH];   // Register contents
  logic [DEPTH-1:0] valid;   // Location holds readable data

  // Write port and registered read
  always_ff @(posedge sys_clk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
    if (srst)
    begin
      valid   <= '0;
      rd_data <= UNDEF_FILL;
    end
    else
    begin
      if (wr_en)
        valid[wr_addr] <= 1'b1;
      // Unwritten (reserved) locations read as fill value
      rd_data <= valid[rd_addr] ? mem[rd_addr] : UNDEF_FILL; // see [R11]
    end
  end

endmodule // mode_reg_store

`default_nettype wire

/* rtl/mrr_pkg.sv */
// Package of constants for the mode-register readout path
package mrr_pkg;

  // ==========================================================
  // Register addresses (8-bit mode-register address space)
  // ==========================================================
  localparam logic [7:0] ADDR_TEMP_STATUS = 8'h04;
  localparam logic [7:0] ADDR_TRAIN_A     = 8'h20;
  localparam logic [7:0] ADDR_TRAIN_B     = 8'h28;

  // ==========================================================
  // Calibration patterns, bit time 0 in bit 0
  // ==========================================================
  localparam logic [3:0] PATTERN_A = 4'h5;
  localparam logic [3:0] PATTERN_B = 4'hC;

  // ==========================================================
  // Burst and command timing, reset and fill values
  // ==========================================================
  localparam int         BURST_BEATS    = 4;
  localparam int         CMD_PERIOD_CYC = 2;
  localparam logic [7:0] TEMP_RESET     = 8'h03;
  localparam logic [7:0] UNDEF_FILL     = 8'h00;

  // Sensor update interval and its cycle count (longest time, rounds down)
  localparam longint SENSOR_INTERVAL_MS = 32;
  localparam longint CLK_PERIOD_PS      = 10000;
  localparam longint SENSOR_INTERVAL_CYC =
    (SENSOR_INTERVAL_MS * 64'd1000000000) / CLK_PERIOD_PS;

  // Command decoder states
  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'b00,
    ST_FALL  = 2'b01,
    ST_WAIT  = 2'b10,
    ST_BURST = 2'b11
  } rd_state_t;

endpackage : mrr_pkg

/* rtl/temp_sampler.sv */
// Temperature status holder refreshed at the sensor interval
`timescale 1ns/1ps
`default_nettype none

module temp_sampler
  import mrr_pkg::*;
#(
  parameter longint INTERVAL_CYC = SENSOR_INTERVAL_CYC
)
(
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic [7:0] sensor_code,
  input  wire logic       wake_event,
  output var  logic [7:0] status
);

  // ==========================================================
  // Interval counter
  // ==========================================================
  logic [31:0] tick_cnt;   // Cycles since last update
  wire         tick_due = (tick_cnt >= 32'(INTERVAL_CYC - 1));

  // Update on interval or on wake so status is never stale
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      tick_cnt <= 32'h0;
      status   <= TEMP_RESET;
    end
    else if (tick_due || wake_event) // see [R17] see [R18]
    begin
      tick_cnt <= 32'h0;
      status   <= sensor_code;
    end
    else
    begin
      tick_cnt <= tick_cnt + 32'h1;
    end
  end

endmodule // temp_sampler

`default_nettype wire

/* verification/mode_reg_readout_bench.sv */
// Self-checking bench for the mode-register readout block
`timescale 1ns/1ps
`default_nettype none

module mode_reg_readout_bench;
  import mrr_pkg::*;
  localparam int     DW = 32;  // Data width
  localparam int     RL = 3;   // Read latency
  localparam longint SC = 100; // Short sensor interval
  logic               sys_clk, srst, go, banks_active, wake_event, cfg_wr_en;
  logic [7:0]         addr, sensor_code, cfg_wr_addr, cfg_wr_data;
  wire logic          chip_select_n, dq_oe, dqs_oe, bank_active_state;
  wire logic [9:0]    ca, caf;
  wire logic [DW-1:0] dq_out;
  wire logic [3:0]    dqs_t, dqs_c;
  int                 miscompares = 0, compares = 0, cyc = 0;

  mode_reg_readout #(.DQ_WIDTH(DW), .READ_LATENCY(RL), .SENSOR_CYC(SC)) u_mode_reg_readout (
    .sys_clk(sys_clk), .srst(srst), .chip_select_n(chip_select_n),
    .command_address(ca), .command_address_fall(caf), .banks_active(banks_active),
    .sensor_code(sensor_code), .wake_event(wake_event), .cfg_wr_en(cfg_wr_en),
    .cfg_wr_addr(cfg_wr_addr), .cfg_wr_data(cfg_wr_data), .dq_out(dq_out),
    .dq_oe(dq_oe), .dqs_t(dqs_t), .dqs_c(dqs_c), .dqs_oe(dqs_oe),
    .bank_active_state(bank_active_state));
  mrr_controller_model u_mrr_controller_model (
    .sys_clk(sys_clk), .go(go), .addr(addr), .chip_select_n(chip_select_n),
    .command_address(ca), .command_address_fall(caf));

  // ==========================================================
  // Clock, timeout, checking helpers
  // ==========================================================
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Hang guard
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      miscompares++;
      results();
    end
  end
  // Compare and report
  task check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task results;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Expected beat k of a read of register a holding d
  function logic [DW-1:0] exp_beat(input logic [7:0] a, input logic [7:0] d, input int k);
    if (a == ADDR_TRAIN_A) return {DW{PATTERN_A[k]}};
    if (a == ADDR_TRAIN_B) return {DW{PATTERN_B[k]}};
    return (k == 0) ? DW'(d) : '0;
  endfunction
  // One readout; dup sends a second command into the busy window
  task rd(input logic [7:0] a, input logic [7:0] d, input bit dup);
    int n;
    addr = a;
    go = 1'b1;
    @(posedge sys_clk);
    #1 go = 1'b0;
    n = 0;
    while (dq_oe !== 1'b1 && n < 20)
    begin
      @(posedge sys_clk);
      #1 n++;
      go = dup && n == 2;
    end
    check(DW'(n), DW'(RL + 3));
    for (int k = 0; k < 4; k++)
    begin
      check(dq_out, exp_beat(a, d, k));
      check(DW'(dqs_oe), DW'(1));
      @(posedge sys_clk);
      #1;
    end
    check(DW'(dq_oe), '0);
  endtask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial
  begin
    srst = 1'b1;
    go = 1'b0;
    addr = 8'h00;
    banks_active = 1'b0;
    sensor_code = 8'h00;
    wake_event = 1'b0;
    cfg_wr_en = 1'b0;
    cfg_wr_addr = 8'h00;
    cfg_wr_data = 8'h00;
    void'($urandom(32'h1052));
    repeat (3) @(posedge sys_clk);
    #1 srst = 1'b0;
    check(DW'({dq_oe, dqs_t, dqs_c}), DW'(9'h00F));
    rd(ADDR_TEMP_STATUS, TEMP_RESET, 1'b0);
    sensor_code = 8'($urandom);
    repeat (SC) @(posedge sys_clk);
    #1;
    rd(ADDR_TEMP_STATUS, sensor_code, 1'b0);
    sensor_code = ~sensor_code;
    wake_event = 1'b1;
    @(posedge sys_clk);
    #1 wake_event = 1'b0;
    rd(ADDR_TEMP_STATUS, sensor_code, 1'b0);
    rd(ADDR_TRAIN_A, 8'h00, 1'b0);
    rd(ADDR_TRAIN_B, 8'h00, 1'b1);
    rd(8'h7F, 8'h00, 1'b0);
    repeat (6)
    begin
      cfg_wr_addr = 8'($urandom) | 8'h80;
      cfg_wr_data = 8'($urandom);
      cfg_wr_en = 1'b1;
      banks_active = 1'($urandom);
      @(posedge sys_clk);
      #1 cfg_wr_en = 1'b0;
      rd(cfg_wr_addr, cfg_wr_data, 1'($urandom));
      check(DW'(bank_active_state), DW'(banks_active));
    end
    results();
  end
endmodule // mode_reg_readout_bench
`default_nettype wire

/* verification/mrr_assertions.sv */
// Port checks for the mode-register readout block
`timescale 1ns/1ps
`default_nettype none

module mrr_chk
#(
  parameter int DQ_WIDTH     = 32,
  parameter int READ_LATENCY = 3
)
(
  input wire logic                  sys_clk,
  input wire logic                  srst,
  input wire logic                  chip_select_n,
  input wire logic [9:0]            command_address,
  input wire logic                  banks_active,
  input wire logic                  dq_oe,
  input wire logic                  dqs_oe,
  input wire logic [DQ_WIDTH/8-1:0] dqs_t,
  input wire logic [DQ_WIDTH/8-1:0] dqs_c,
  input wire logic                  bank_active_state
);
  // ==========================================================
  // Busy window of one readout
  // ==========================================================
  localparam int LAT = READ_LATENCY + 3; // Edges until first beat is seen
  logic [3:0] cnt;  // Cycles left in the readout
  wire logic  take; // Read command accepted
  assign take = !chip_select_n && command_address[3:0] == 4'h8 && cnt == 4'h0;
  // Load on an accepted command, then count down to idle
  always_ff @(posedge sys_clk)
  begin
    if (srst) cnt <= 4'h0;
    else if (take) cnt <= 4'(LAT + 3);
    else if (cnt != 4'h0) cnt <= cnt - 4'h1;
  end
  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  a_cmd_to_data: assert property (take |-> ##LAT dq_oe)
    else $error("no data after read command");
  a_no_early: assert property (cnt > 4'h4 |-> !dq_oe)
    else $error("data too early");
  a_burst_four: assert property ($rose(dq_oe) |-> dq_oe [*4] ##1 !dq_oe)
    else $error("burst not four beats");
  a_busy_only: assert property (dq_oe |-> cnt inside {[4'h1:4'h4]})
    else $error("burst without accepted command");
  a_strobe_data: assert property (dqs_oe == dq_oe)
    else $error("strobe enable differs from data");
  a_strobe_pair: assert property (dqs_oe |-> dqs_c == ~dqs_t)
    else $error("strobe pair not complementary");
  a_strobe_toggle: assert property (dqs_oe && $past(dqs_oe) |-> &(dqs_t ^ $past(dqs_t)))
    else $error("strobe did not toggle");
  a_bank_follow: assert property (!srst |=> bank_active_state == $past(banks_active))
    else $error("bank state lost");
  c_read: cover property (take);
  c_refused: cover property (!chip_select_n && command_address[3:0] == 4'h8 && cnt != 4'h0);
  c_active: cover property ($rose(dq_oe) && banks_active);
endmodule // mrr_chk

bind mode_reg_readout mrr_chk #(.DQ_WIDTH(DQ_WIDTH), .READ_LATENCY(READ_LATENCY)) u_mrr_chk (
  .sys_clk(sys_clk), .srst(srst), .chip_select_n(chip_select_n),
  .command_address(command_address), .banks_active(banks_active), .dq_oe(dq_oe),
  .dqs_oe(dqs_oe), .dqs_t(dqs_t), .dqs_c(dqs_c), .bank_active_state(bank_active_state));
`default_nettype wire

/* verification/mrr_controller_model.sv */
// Controller model driving the command/address bus
`timescale 1ns/1ps
`default_nettype none

module mrr_controller_model
(
  input  wire logic       sys_clk,
  input  wire logic       go,
  input  wire logic [7:0] addr,
  output var  logic       chip_select_n,
  output var  logic [9:0] command_address,
  output var  logic [9:0] command_address_fall
);
  logic       g;    // Request seen at this edge
  logic       pend; // Falling-edge half still owed
  logic [7:0] a;    // Register address of the request
  initial
  begin
    chip_select_n = 1'b1;
    command_address = 10'h000;
    command_address_fall = 10'h000;
    pend = 1'b0;
  end
  // Sample at the edge, drive just after; idle lines keep changing
  always @(posedge sys_clk)
  begin
    g = go;
    if (g) a = addr;
    #1;
    command_address_fall = pend ? {~command_address_fall[9:2], a[7:6]}
                                : ~command_address_fall;
    // Commands only when asked; bench spaces them past each burst except a dup read sent into the busy window, no other ops
    chip_select_n = !g;
    command_address = g ? {a[5:0], 4'h8} : ~command_address;
    pend = g;
  end
endmodule // mrr_controller_model
`default_nettype wire
